// ---- src/strap_led_top.sv ----
// strap sampling on shared pins and per-port status indicators
//
// Summary of operation
// R01: transmit clock follows reference when selected
// R02: per-port transmit activity indicator
// R03: carrier integrity strap ORed with ctrl bit 3
// R04: coder bypass strap ORed, all channels
// R05: scrambler bypass strap ORed with bit 4
// R06: reference select strap ORed with cfg bit 2
// R07: per-port receive activity indicator
// R08: fiber strap per channel ORed bit 0
// R09: per-port collision indicator
// R10: port D link indicator shows link
// R11: phy address bit 2 from port D link
// R12: address bits 1,0 from ports C, B
// R13: capture straps in reset, then drive pins
// R14: strap governs, register may also enable
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module strap_led_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb register bus
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // clocks
  input  wire logic        twenty_meg_clock_in,
  input  wire logic        ten_meg_reference_in,
  output logic             tx_clk_out,
  // per-port status from the channels
  input  wire logic [3:0]  tx_active,
  input  wire logic [3:0]  rx_active,
  input  wire logic [3:0]  col_active,
  input  wire logic [3:0]  link_good,
  // transmit pins: [3] carrier, [2] coder, [1] scrambler, [0] refsel
  input  wire logic [3:0]  tx_activity_indicator_i,
  output logic [3:0]       tx_activity_indicator_o,
  output logic [3:0]       tx_activity_indicator_oe,
  // receive pins, fiber mode straps
  input  wire logic [3:0]  rx_activity_indicator_i,
  output logic [3:0]       rx_activity_indicator_o,
  output logic [3:0]       rx_activity_indicator_oe,
  // collision outputs
  output logic [3:0]       collision_indicator,
  // link pins: [3:1] carry the phy address straps
  input  wire logic [3:0]  link_good_indicator_i,
  output logic [3:0]       link_good_indicator_o,
  output logic [3:0]       link_good_indicator_oe,
  // resolved configuration
  output logic [2:0]       phy_address_strap,
  output logic [3:0]       fiber_mode,
  output logic             carrier_integrity_en,
  output logic             coder_bypass_en,
  output logic             scrambler_bypass_en,
  output logic             ref_select_en
);
  import strap_pkg::*;

  logic        capture;
  logic        sampled_q;
  logic [3:0]  tx_strap;
  logic [3:0]  rx_strap;
  logic [3:0]  link_strap;
  logic [15:0] ctrl_q;
  logic [15:0] cfg_q;
  logic [15:0] ctrl_rd;
  logic [15:0] cfg_rd;
  logic [15:0] phy_rd;
  logic [15:0] act_rd;
  logic        carrier_integrity_strap;
  logic        coder_bypass_strap;
  logic        scrambler_bypass_strap;
  logic        ref_select_strap;
  logic [3:0]  fiber_mode_strap;

  // capture window is the reset period itself
  assign capture = ~rst_n; // [R13]

  // pins drive only once straps are held
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sampled_q <= 1'b0;
    end else begin
      sampled_q <= 1'b1; // [R13]
    end
  end

  // capture cells for every shared pin
  // transmit pins: one device-wide strap each
  // port d pin: carrier integrity strap
  strap_latch u_cap_carrier (
    .clk     (clk),
    .rst_n   (rst_n),
    .capture (capture),
    .pin_in  (tx_activity_indicator_i[3]),
    .value_q (tx_strap[3])
  );
  // port c pin: coder bypass strap
  strap_latch u_cap_coder (
    .clk     (clk),
    .rst_n   (rst_n),
    .capture (capture),
    .pin_in  (tx_activity_indicator_i[2]),
    .value_q (tx_strap[2])
  );
  // port b pin: scrambler bypass strap
  strap_latch u_cap_scram (
    .clk     (clk),
    .rst_n   (rst_n),
    .capture (capture),
    .pin_in  (tx_activity_indicator_i[1]),
    .value_q (tx_strap[1])
  );
  // port a pin: reference select strap
  strap_latch u_cap_refsel (
    .clk     (clk),
    .rst_n   (rst_n),
    .capture (capture),
    .pin_in  (tx_activity_indicator_i[0]),
    .value_q (tx_strap[0])
  );

  // receive pins: fiber mode strap of each channel
  // channel a fiber strap
  strap_latch u_cap_fiber_a (
    .clk     (clk),
    .rst_n   (rst_n),
    .capture (capture),
    .pin_in  (rx_activity_indicator_i[0]),
    .value_q (rx_strap[0])
  );
  // channel b fiber strap
  strap_latch u_cap_fiber_b (
    .clk     (clk),
    .rst_n   (rst_n),
    .capture (capture),
    .pin_in  (rx_activity_indicator_i[1]),
    .value_q (rx_strap[1])
  );
  // channel c fiber strap
  strap_latch u_cap_fiber_c (
    .clk     (clk),
    .rst_n   (rst_n),
    .capture (capture),
    .pin_in  (rx_activity_indicator_i[2]),
    .value_q (rx_strap[2])
  );
  // channel d fiber strap
  strap_latch u_cap_fiber_d (
    .clk     (clk),
    .rst_n   (rst_n),
    .capture (capture),
    .pin_in  (rx_activity_indicator_i[3]),
    .value_q (rx_strap[3])
  );

  // link pins: address straps on b, c, d
  // port a link pin, held but not used
  strap_latch u_cap_link_a (
    .clk     (clk),
    .rst_n   (rst_n),
    .capture (capture),
    .pin_in  (link_good_indicator_i[0]),
    .value_q (link_strap[0])
  );
  // port b link pin: address bit 0
  strap_latch u_cap_link_b (
    .clk     (clk),
    .rst_n   (rst_n),
    .capture (capture),
    .pin_in  (link_good_indicator_i[1]),
    .value_q (link_strap[1])
  );
  // port c link pin: address bit 1
  strap_latch u_cap_link_c (
    .clk     (clk),
    .rst_n   (rst_n),
    .capture (capture),
    .pin_in  (link_good_indicator_i[2]),
    .value_q (link_strap[2])
  );
  // port d link pin: address bit 2
  strap_latch u_cap_link_d (
    .clk     (clk),
    .rst_n   (rst_n),
    .capture (capture),
    .pin_in  (link_good_indicator_i[3]),
    .value_q (link_strap[3])
  );

  // name the sampled straps
  assign carrier_integrity_strap = tx_strap[3];
  assign coder_bypass_strap      = tx_strap[2];
  assign scrambler_bypass_strap  = tx_strap[1];
  assign ref_select_strap        = tx_strap[0];
  assign fiber_mode_strap        = rx_strap;

  // phy address from link pins D, C, B
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phy_address_strap <= 3'h0;
    end else begin
      phy_address_strap[2] <= link_strap[3]; // [R11]
      phy_address_strap[1] <= link_strap[2]; // [R12]
      phy_address_strap[0] <= link_strap[1]; // [R12]
    end
  end

  // strap ORed with management bits, held in flops
  // carrier integrity monitor enable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      carrier_integrity_en <= 1'b0;
    end else begin
      carrier_integrity_en <= carrier_integrity_strap
                              | ctrl_q[BIT_CARRIER]; // [R03] [R14]
    end
  end

  // coder bypass, shared by all four channels
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      coder_bypass_en <= 1'b0;
    end else begin
      coder_bypass_en <= coder_bypass_strap
                         | ctrl_q[BIT_CODER]; // [R04] [R14]
    end
  end

  // scrambler bypass
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scrambler_bypass_en <= 1'b0;
    end else begin
      scrambler_bypass_en <= scrambler_bypass_strap
                             | ctrl_q[BIT_SCRAM]; // [R05] [R14]
    end
  end

  // reference clock select
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ref_select_en <= 1'b0;
    end else begin
      ref_select_en <= ref_select_strap
                       | cfg_q[BIT_REFSEL]; // [R06] [R14]
    end
  end

  // fiber mode per channel, register bit covers all
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fiber_mode <= 4'h0;
    end else begin
      fiber_mode <= fiber_mode_strap
                    | {4{ctrl_q[BIT_FIBER]}}; // [R08] [R14]
    end
  end

  // transmit clock source select
  assign tx_clk_out = ref_select_en ? ten_meg_reference_in // [R01]
                                    : twenty_meg_clock_in;

  // indicator outputs from flops
  // transmit activity per port
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_activity_indicator_o <= 4'h0;
    end else begin
      tx_activity_indicator_o <= tx_active; // [R02]
    end
  end

  // receive activity per port
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_activity_indicator_o <= 4'h0;
    end else begin
      rx_activity_indicator_o <= rx_active; // [R07]
    end
  end

  // collision per port
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      collision_indicator <= 4'h0;
    end else begin
      collision_indicator <= col_active; // [R09]
    end
  end

  // link good per port, port d included
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link_good_indicator_o <= 4'h0;
    end else begin
      link_good_indicator_o <= link_good; // [R10]
    end
  end

  // shared pins released during reset so straps can be read
  assign tx_activity_indicator_oe = {4{sampled_q}}; // [R13]
  assign rx_activity_indicator_oe = {4{sampled_q}}; // [R13]
  assign link_good_indicator_oe   = {4{sampled_q}}; // [R13]

  // readback views
  assign ctrl_rd = ctrl_q;
  // cfg view overlays the straps-held flag
  always_comb begin
    cfg_rd              = cfg_q;
    cfg_rd[BIT_SAMPLED] = sampled_q; // [R13]
  end
  assign phy_rd  = {1'b0, ref_select_en, scrambler_bypass_en,
                    coder_bypass_en, carrier_integrity_en,
                    fiber_mode, tx_strap, phy_address_strap};
  assign act_rd  = {tx_activity_indicator_o, rx_activity_indicator_o,
                    collision_indicator, link_good_indicator_o};

  // register bus slave
  apb_regs u_regs (
    .clk     (clk),
    .rst_n   (rst_n),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .ctrl_q  (ctrl_q),
    .cfg_q   (cfg_q),
    .ctrl_rd (ctrl_rd),
    .cfg_rd  (cfg_rd),
    .phy_rd  (phy_rd),
    .act_rd  (act_rd)
  );
endmodule

// ---- shared/strap_pkg.sv ----
// constants for the strap sampling and status indicator block
package strap_pkg;
  localparam int unsigned NUM_PORTS = 4;
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_CFG      = 8'h04;
  localparam logic [7:0] ADDR_PHYADDR  = 8'h08;
  localparam logic [7:0] ADDR_ACTIVITY = 8'h0c;
  localparam int unsigned BIT_FIBER   = 0;
  localparam int unsigned BIT_CARRIER = 3;
  localparam int unsigned BIT_SCRAM   = 4;
  localparam int unsigned BIT_CODER   = 6;
  localparam int unsigned BIT_REFSEL  = 2;
  localparam logic [15:0] CTRL_RESET  = 16'h0000;
  localparam logic [15:0] CFG_RESET   = 16'h0000;
  localparam int unsigned BIT_SAMPLED = 8;
  localparam int unsigned CLK_MHZ     = 100;
  localparam int unsigned SETTLE_NS   = 100;
  localparam int unsigned SETTLE_CYC  = (SETTLE_NS * CLK_MHZ + 999) / 1000;
endpackage

// ---- src/strap_latch.sv ----
// one strap capture cell: samples in reset, holds after
`timescale 1ns/1ps
module strap_latch (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // capture control
  input  wire logic capture,
  input  wire logic pin_in,
  // held level
  output logic      value_q
);
  // capture only while strobe high, hold otherwise
  always_ff @(posedge clk) begin
    if (capture) begin
      value_q <= pin_in;
    end
  end
endmodule

// ---- src/apb_regs.sv ----
// apb slave holding the management register bits
`timescale 1ns/1ps
module apb_regs (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // register contents and status
  output logic [15:0]      ctrl_q,
  output logic [15:0]      cfg_q,
  input  wire logic [15:0] ctrl_rd,
  input  wire logic [15:0] cfg_rd,
  input  wire logic [15:0] phy_rd,
  input  wire logic [15:0] act_rd
);
  import strap_pkg::*;
  logic acc;
  logic hit;
  assign acc = psel & penable;
  assign pready = 1'b1;
  // address decode
  always_comb begin
    if (paddr == ADDR_CTRL) begin
      hit = 1'b1;
    end else if (paddr == ADDR_CFG) begin
      hit = 1'b1;
    end else if (paddr == ADDR_PHYADDR) begin
      hit = 1'b1;
    end else if (paddr == ADDR_ACTIVITY) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end
  assign pslverr = acc & ~hit;
  // writable management bits
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RESET;
      cfg_q  <= CFG_RESET;
    end else if (acc && pwrite) begin
      if (paddr == ADDR_CTRL) begin
        ctrl_q <= pwdata[15:0];
      end else if (paddr == ADDR_CFG) begin
        cfg_q <= pwdata[15:0];
      end
    end
  end
  // registered read data, valid in access phase
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == ADDR_CTRL) begin
        prdata <= {16'h0000, ctrl_rd};
      end else if (paddr == ADDR_CFG) begin
        prdata <= {16'h0000, cfg_rd};
      end else if (paddr == ADDR_PHYADDR) begin
        prdata <= {16'h0000, phy_rd};
      end else if (paddr == ADDR_ACTIVITY) begin
        prdata <= {16'h0000, act_rd};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end
endmodule

// ---- dv/strap_board.sv ----
// board strap resistors and led buffers on one group of shared pins
`timescale 1ns/1ps
module strap_board (
  // resistor level on each pin
  input  wire logic [3:0] strap,
  // device side of the pins
  input  wire logic [3:0] pin_o,
  input  wire logic [3:0] pin_oe,
  output logic [3:0]      pin_i
);
  // resistor sets the level only where the device is not driving
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & strap);
endmodule

// ---- dv/strap_led_top_sva.sv ----
// assertions on the strap sampling and indicator ports
`timescale 1ns/1ps
module strap_led_top_sva (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // clocks and channel status
  input wire logic       twenty_meg_clock_in,
  input wire logic       ten_meg_reference_in,
  input wire logic       tx_clk_out,
  input wire logic [3:0] tx_active,
  input wire logic [3:0] rx_active,
  input wire logic [3:0] col_active,
  input wire logic [3:0] link_good,
  // shared pins
  input wire logic [3:0] tx_activity_indicator_i,
  input wire logic [3:0] tx_activity_indicator_o,
  input wire logic [3:0] tx_activity_indicator_oe,
  input wire logic [3:0] rx_activity_indicator_i,
  input wire logic [3:0] rx_activity_indicator_o,
  input wire logic [3:0] collision_indicator,
  input wire logic [3:0] link_good_indicator_i,
  input wire logic [3:0] link_good_indicator_o,
  // resolved configuration
  input wire logic [2:0] phy_address_strap,
  input wire logic [3:0] fiber_mode,
  input wire logic       carrier_integrity_en,
  input wire logic       coder_bypass_en,
  input wire logic       scrambler_bypass_en,
  input wire logic       ref_select_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // first edge with reset released
  sequence rel_s;
    $rose(rst_n);
  endsequence
  // clock source, indicators and strap capture
  a_ref_clock: assert property (
    tx_clk_out == (ref_select_en ? ten_meg_reference_in
                   : twenty_meg_clock_in)) else $error("tx clock source");
  a_tx_follow: assert property ($past(rst_n) |->
    tx_activity_indicator_o == $past(tx_active)) else $error("tx led");
  a_rx_follow: assert property ($past(rst_n) |->
    rx_activity_indicator_o == $past(rx_active)) else $error("rx led");
  a_col_follow: assert property ($past(rst_n) |->
    collision_indicator == $past(col_active)) else $error("col led");
  a_link_follow: assert property ($past(rst_n) |->
    link_good_indicator_o == $past(link_good)) else $error("link led");
  a_addr_latch: assert property (rel_s |=>
    phy_address_strap == $past(link_good_indicator_i[3:1], 2))
    else $error("phy address");
  a_strap_or: assert property (rel_s |=>
    ($past({rx_activity_indicator_i, tx_activity_indicator_i}, 2) &
     ~{fiber_mode, carrier_integrity_en, coder_bypass_en,
       scrambler_bypass_en, ref_select_en}) == 8'h00)
    else $error("strap not applied");
  a_addr_held: assert property ($past(rst_n, 2) && $past(rst_n) |->
    $stable(phy_address_strap)) else $error("address moved");
  a_pins_taken: assert property (rel_s |->
    tx_activity_indicator_oe == 4'h0 ##1 tx_activity_indicator_oe == 4'hf)
    else $error("pins not driven");
endmodule

// ---- dv/strap_led_top_tb.sv ----
// self-checking bench for strap sampling and status indicators
`timescale 1ns/1ps
module strap_led_top_tb;
  import strap_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic        twenty_meg_clock_in, ten_meg_reference_in, tx_clk_out;
  logic        carrier_integrity_en, coder_bypass_en;
  logic        scrambler_bypass_en, ref_select_en;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] pat;
  logic [2:0]  phy_address_strap;
  logic [3:0]  tx_active, rx_active, col_active, link_good, fiber_mode;
  logic [3:0]  tx_activity_indicator_i, tx_activity_indicator_o;
  logic [3:0]  tx_activity_indicator_oe, rx_activity_indicator_i;
  logic [3:0]  rx_activity_indicator_o, rx_activity_indicator_oe;
  logic [3:0]  link_good_indicator_i, link_good_indicator_o;
  logic [3:0]  link_good_indicator_oe, collision_indicator;
  logic [3:0]  tx_strap, rx_strap, link_strap;
  int          fail_count, total_checks, cycles;

  strap_led_top u_strap_led_top (.clk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .twenty_meg_clock_in,
    .ten_meg_reference_in, .tx_clk_out, .tx_active, .rx_active, .col_active,
    .link_good, .tx_activity_indicator_i, .tx_activity_indicator_o,
    .tx_activity_indicator_oe, .rx_activity_indicator_i,
    .rx_activity_indicator_o, .rx_activity_indicator_oe,
    .collision_indicator, .link_good_indicator_i, .link_good_indicator_o,
    .link_good_indicator_oe, .phy_address_strap, .fiber_mode,
    .carrier_integrity_en, .coder_bypass_en, .scrambler_bypass_en,
    .ref_select_en);
  strap_board u_strap_board_tx (.strap(tx_strap),
    .pin_o(tx_activity_indicator_o), .pin_oe(tx_activity_indicator_oe),
    .pin_i(tx_activity_indicator_i));
  strap_board u_strap_board_rx (.strap(rx_strap),
    .pin_o(rx_activity_indicator_o), .pin_oe(rx_activity_indicator_oe),
    .pin_i(rx_activity_indicator_i));
  strap_board u_strap_board_link (.strap(link_strap),
    .pin_o(link_good_indicator_o), .pin_oe(link_good_indicator_oe),
    .pin_i(link_good_indicator_i));

  // clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer, read data and error kept in rd and err
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // reset for 8 cycles with the given board straps
  task automatic do_reset(input logic [3:0] t, input logic [3:0] r,
                          input logic [3:0] l);
    tx_strap   <= t;
    rx_strap   <= r;
    link_strap <= l;
    rst_n      <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n      <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  task automatic chk_cfg(input logic [2:0] a, input logic [3:0] f,
                         input logic [3:0] c);
    chk(32'(phy_address_strap), 32'(a));
    chk(32'(fiber_mode), 32'(f));
    chk(32'({carrier_integrity_en, coder_bypass_en, scrambler_bypass_en,
             ref_select_en}), 32'(c));
  endtask

  // main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {tx_active, rx_active, col_active, link_good} = '0;
    {twenty_meg_clock_in, ten_meg_reference_in} = 2'b10;
    do_reset(4'ha, 4'h6, 4'ha);
    chk_cfg(3'h5, 4'h6, 4'ha);
    chk(32'({tx_activity_indicator_oe, rx_activity_indicator_oe,
             link_good_indicator_oe}), 32'hfff);
    chk(32'(tx_clk_out), 32'(twenty_meg_clock_in));
    // straps move after release, configuration must not
    tx_strap   <= 4'h5;
    rx_strap   <= 4'h9;
    link_strap <= 4'h4;
    repeat (3) @(posedge clk);
    chk_cfg(3'h5, 4'h6, 4'ha);
    // a different port on each indicator group per step
    for (int p = 0; p < 4; p++) begin
      pat = {4'(1 << p), 4'(1 << ((p + 1) % 4)), 4'(1 << ((p + 2) % 4)),
             4'(1 << ((p + 3) % 4))};
      {tx_active, rx_active, col_active, link_good} <= pat;
      repeat (2) @(posedge clk);
      chk(32'({tx_activity_indicator_o, rx_activity_indicator_o,
               collision_indicator, link_good_indicator_o}),
          32'(pat));
      apb(1'b0, ADDR_ACTIVITY, 32'h0);
      chk(rd, 32'(pat));
    end
    // register bits ORed with the straps
    apb(1'b1, ADDR_CTRL, 32'h59);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h59);
    chk(32'(err), 32'h0);
    chk_cfg(3'h5, 4'hf, 4'he);
    apb(1'b1, ADDR_CFG, 32'h4);
    repeat (2) @(posedge clk); // setting lands one edge after the write
    chk(32'(tx_clk_out), 32'(ten_meg_reference_in));
    apb(1'b0, ADDR_CFG, 32'h0);
    chk(rd, 32'h104);
    // read-only status ignores writes, unmapped address refused
    apb(1'b1, ADDR_PHYADDR, 32'h0);
    apb(1'b0, ADDR_PHYADDR, 32'h0);
    chk(rd, 32'h7fd5);
    apb(1'b0, 8'h40, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    // second reset, registers cleared, new straps
    do_reset(4'h5, 4'h9, 4'h4);
    chk_cfg(3'h2, 4'h9, 4'h5);
    chk(32'(tx_clk_out), 32'(ten_meg_reference_in));
    end_of_test();
  end
endmodule

bind strap_led_top strap_led_top_sva u_strap_led_top_sva (.clk, .rst_n,
  .twenty_meg_clock_in, .ten_meg_reference_in, .tx_clk_out, .tx_active,
  .rx_active, .col_active, .link_good, .tx_activity_indicator_i,
  .tx_activity_indicator_o, .tx_activity_indicator_oe,
  .rx_activity_indicator_i, .rx_activity_indicator_o, .collision_indicator,
  .link_good_indicator_i, .link_good_indicator_o, .phy_address_strap,
  .fiber_mode, .carrier_integrity_en, .coder_bypass_en,
  .scrambler_bypass_en, .ref_select_en);
